// >>> sfag_flash_model.sv
`timescale 1ns/100ps
module sfag_flash_model
  import sfag_pkg::*;
#(
  parameter int unsigned FLASH_KB = 60,
  parameter int unsigned SLOW_LAT = 6
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire sfag_pkg::sfag_flash_cmd_s flashCmd,
  input wire logic flashCmdValid,
  output logic flashDone
);
  logic [7:0] mem [0:65535];
  int nCmd = 0;
  int waitCnt = 0;
  int lo;
  int hi;

  // Contents survive reset, as a real array does
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'hFF;
    end
  end

  always @(posedge sys_clk) begin
    flashDone <= 1'b0;
    if (rst) begin
      waitCnt <= 0;
    end else if (flashCmdValid) begin
      nCmd <= nCmd + 1;
      // Commands with even nCmd finish slowly, odd ones fast; the first command is slow
      waitCnt <= (nCmd % 2) ? 1 : SLOW_LAT;
      case (flashCmd.op)
        OP_PROG: mem[flashCmd.addr] = flashCmd.data;
        OP_MERASE: begin
          for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'hFF;
          end
        end
        OP_SERASE: begin
          if (flashCmd.addr >= SFAG_SEC0_BASE) begin
            lo = 32'h0000_F000;
            hi = 32'h0000_FFFF;
          end else if (flashCmd.addr >= SFAG_SEC1_BASE) begin
            lo = 32'h0000_E000;
            hi = 32'h0000_EFFF;
          end else begin
            lo = 32'h0001_0000 - FLASH_KB * 1024;
            hi = 32'h0000_DFFF;
          end
          for (int i = lo; i <= hi; i++) begin
            mem[i] = 8'hFF;
          end
        end
        default: ;
      endcase
    end else if (waitCnt > 0) begin
      waitCnt <= waitCnt - 1;
      if (waitCnt == 1) begin
        flashDone <= 1'b1;
      end
    end
  end
endmodule // sfag_flash_model

// >>> sfag_pkg.sv
package sfag_pkg;

  // Register map of the access port
  localparam logic [7:0] SFAG_CSR_ADDR = 8'h29;
  localparam logic [7:0] SFAG_ADRL_ADDR = 8'h2A;
  localparam logic [7:0] SFAG_ADRH_ADDR = 8'h2B;
  localparam logic [7:0] SFAG_DATA_ADDR = 8'h2C;
  localparam logic [7:0] SFAG_OPT_ADDR = 8'h2D;
  localparam logic [7:0] SFAG_CSR_RESET = 8'h00;
  localparam logic [7:0] SFAG_ZERO_BYTE = 8'h00;

  // Control/status field positions
  localparam int unsigned CSR_PROG_BIT = 0;
  localparam int unsigned CSR_SERASE_BIT = 1;
  localparam int unsigned CSR_MERASE_BIT = 2;
  localparam int unsigned CSR_BUSY_BIT = 3;
  localparam int unsigned CSR_REFUSE_BIT = 4;
  localparam int unsigned CSR_DONE_BIT = 5;

  // Option byte field
  localparam int unsigned OPT_PROTECT_BIT = 0;

  // Sector geometry
  localparam int unsigned SFAG_FLASH_KB_DEF = 60;
  localparam int unsigned SFAG_SECTOR_KB = 4;
  localparam logic [15:0] SFAG_SEC0_BASE = 16'hF000;
  localparam logic [15:0] SFAG_SEC1_BASE = 16'hE000;
  localparam logic [16:0] SFAG_ADDR_TOP = 17'h1_0000;
  localparam logic [1:0] SFAG_SEC0 = 2'h0;
  localparam logic [1:0] SFAG_SEC1 = 2'h1;
  localparam logic [1:0] SFAG_SEC2 = 2'h2;

  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_PROG = 2'h1,
    OP_SERASE = 2'h2,
    OP_MERASE = 2'h3
  } sfag_op_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_UNPROT = 3'h4
  } sfag_state_e;

  typedef struct packed {
    sfag_op_e op;
    logic [15:0] addr;
    logic [7:0] data;
  } sfag_flash_cmd_s;

  // Number of user sectors for a given array size
  function automatic int unsigned sfag_sector_count(input int unsigned kb);
    if (kb <= SFAG_SECTOR_KB) begin
      return 1;
    end else if (kb <= 2 * SFAG_SECTOR_KB) begin
      return 2;
    end
    return 3;
  endfunction

endpackage

// >>> sfag_sector_map.sv
`timescale 1ns/100ps
module sfag_sector_map #(
  parameter int unsigned FLASH_KB = sfag_pkg::SFAG_FLASH_KB_DEF
) (
  input wire logic [15:0] addr,
  output logic [1:0] sector,
  output logic inMap
);
  import sfag_pkg::*;

  localparam int unsigned SEC_COUNT = sfag_sector_count(FLASH_KB);
  localparam logic [16:0] ARRAY_BASE = 17'(SFAG_ADDR_TOP - 17'(FLASH_KB * 1024));

  always_comb begin
    sector = SFAG_SEC2;
    inMap = 1'b0;
    if (addr >= SFAG_SEC0_BASE) begin
      sector = SFAG_SEC0;
      inMap = 1'b1;
    end else if (addr >= SFAG_SEC1_BASE) begin
      sector = SFAG_SEC1;
      inMap = (SEC_COUNT > 1);
    end else begin
      inMap = (SEC_COUNT > 2) && ({1'b0, addr} >= ARRAY_BASE);
    end
  end

endmodule // sfag_sector_map

// >>> sfag_top.sv
`timescale 1ns/100ps
// Contract
// [RQ1] Erase whole array or one sector; program one byte at a time.
// [RQ2] Sector count: 4K has sector 0, 8K has 0-1, larger has 0-2.
// [RQ3] Sectors 0 and 1 are 4K each at the top; remainder is sector 2.
// [RQ4] Sector 0 spans F000h to FFFFh, holding reset and interrupt vectors.
// [RQ5] Sector erase or program leaves all other sectors untouched.
// [RQ6] With tool or in-circuit programming, all sectors and options are writable.
// [RQ7] In-application programming refuses writes and erases to sector 0.
// [RQ8] Software must first place a boot loader in sector 0.
// [RQ9] Read-out protection blocks external reads and flash writes.
// [RQ10] Protection follows only the option byte bit, no run-time register.
// [RQ11] Removing protection first erases the whole array automatically.
// [RQ12] Low supply detector unavailable while protection is on.
// [RQ13] Tool must enter in-circuit comm mode before in-circuit programming.
// [RQ14] Tool drives reset in a session; application asserts no reset.
// [RQ15] Serial clock and data pins belong to the tool once attached.
// [RQ16] Control/status register at 0029h resets to 00h, drives operations.
// [RQ17] Refused requests complete without changing flash contents.
module sfag_top #(
  parameter int unsigned FLASH_KB = sfag_pkg::SFAG_FLASH_KB_DEF
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic toolAttached,
  input wire logic incircuitCommMode,
  input wire logic optionStrap,
  input wire logic flashDone,
  output sfag_pkg::sfag_flash_cmd_s flashCmd,
  output logic flashCmdValid,
  output logic optionNvWr,
  output logic optionNvData,
  input wire logic extReadReq,
  output logic extReadGrant,
  output logic lowSupplyDetectorEn,
  output logic iccPinsToTool
);
  import sfag_pkg::*;

  sfag_state_e state_r;
  sfag_flash_cmd_s flashCmd_r;
  logic flashCmdValid_r;
  logic [7:0] addrLo_r;
  logic [7:0] addrHi_r;
  logic [7:0] data_r;
  logic protect_r;
  logic loaded_r;
  logic refuse_r;
  logic done_r;
  logic optionNvWr_r;
  logic optionNvData_r;
  logic extReadGrant_r;
  logic lsdEn_r;
  logic pinsToTool_r;
  logic [7:0] regRdData_r;

  logic [15:0] targetAddr;
  logic [1:0] targetSector;
  logic targetInMap;
  logic privileged;
  logic csrWr;
  logic optWr;
  logic ready;
  sfag_op_e reqOp;
  logic refuseNow;
  logic acceptOp;
  logic unprotStart;
  logic optDirect;
  logic newProtect;

  assign targetAddr = {addrHi_r, addrLo_r};

  sfag_sector_map #(
    .FLASH_KB(FLASH_KB)
  ) u_map (
    .addr(targetAddr),
    .sector(targetSector),
    .inMap(targetInMap)
  );

  // Only a tool-driven session in comm mode may touch sector 0 or options
  assign privileged = toolAttached && incircuitCommMode; // RQ6 RQ13
  assign csrWr = regWrEn && (regAddr == SFAG_CSR_ADDR);
  assign optWr = regWrEn && (regAddr == SFAG_OPT_ADDR);
  assign ready = loaded_r && (state_r == ST_IDLE);
  assign newProtect = regWrData[OPT_PROTECT_BIT];

  // Mass erase outranks sector erase, which outranks program
  always_comb begin
    reqOp = OP_NONE;
    if (csrWr && regWrData[CSR_MERASE_BIT]) begin
      reqOp = OP_MERASE; // RQ1
    end else if (csrWr && regWrData[CSR_SERASE_BIT]) begin
      reqOp = OP_SERASE; // RQ1
    end else if (csrWr && regWrData[CSR_PROG_BIT]) begin
      reqOp = OP_PROG; // RQ1
    end
  end

  function automatic logic opRefused(input sfag_op_e op, input logic prot,
                                     input logic priv, input logic [1:0] sec,
                                     input logic inMap);
    logic r;
    r = 1'b0;
    if (op != OP_NONE) begin
      if (prot) begin
        r = 1'b1; // RQ9
      end else if (op == OP_MERASE) begin
        r = !priv; // RQ7
      end else begin
        r = !inMap || (!priv && (sec == SFAG_SEC0)); // RQ2 RQ7
      end
    end
    return r;
  endfunction

  assign refuseNow = ready && opRefused(reqOp, protect_r, privileged,
                                        targetSector, targetInMap);
  assign acceptOp = ready && (reqOp != OP_NONE) && !refuseNow;
  // Option byte writes outside a privileged session are refused too
  assign unprotStart = ready && (reqOp == OP_NONE) && optWr && privileged
                       && protect_r && !newProtect; // RQ11
  assign optDirect = ready && (reqOp == OP_NONE) && optWr && privileged
                     && !(protect_r && !newProtect); // RQ6

  // Sequencer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (acceptOp) begin
            state_r <= ST_WAIT;
          end else if (unprotStart) begin
            state_r <= ST_UNPROT; // RQ11
          end
        end
        ST_WAIT: begin
          if (flashDone) begin
            state_r <= ST_IDLE;
          end
        end
        ST_UNPROT: begin
          if (flashDone) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Command toward the array: one address per command keeps others intact
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flashCmd_r <= '0;
      flashCmdValid_r <= 1'b0;
    end else begin
      flashCmdValid_r <= 1'b0;
      if (acceptOp) begin
        flashCmd_r.op <= reqOp; // RQ5
        flashCmd_r.addr <= targetAddr; // RQ3 RQ4
        flashCmd_r.data <= data_r;
        flashCmdValid_r <= 1'b1;
      end else if (unprotStart) begin
        flashCmd_r.op <= OP_MERASE; // RQ11
        flashCmd_r.addr <= SFAG_SEC0_BASE;
        flashCmd_r.data <= SFAG_ZERO_BYTE;
        flashCmdValid_r <= 1'b1;
      end
    end
  end

  // Address and data staging registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      addrLo_r <= SFAG_ZERO_BYTE;
      addrHi_r <= SFAG_ZERO_BYTE;
      data_r <= SFAG_ZERO_BYTE;
    end else if (regWrEn) begin
      if (regAddr == SFAG_ADRL_ADDR) begin
        addrLo_r <= regWrData;
      end
      if (regAddr == SFAG_ADRH_ADDR) begin
        addrHi_r <= regWrData;
      end
      if (regAddr == SFAG_DATA_ADDR) begin
        data_r <= regWrData;
      end
    end
  end

  // Protection comes only from the option byte; strap is caught after reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      protect_r <= 1'b0;
      loaded_r <= 1'b0;
      optionNvWr_r <= 1'b0;
      optionNvData_r <= 1'b0;
    end else begin
      optionNvWr_r <= 1'b0;
      if (!loaded_r) begin
        protect_r <= optionStrap; // RQ10
        optionNvData_r <= optionStrap;
        loaded_r <= 1'b1;
      end else if (optDirect) begin
        protect_r <= newProtect; // RQ10
        optionNvData_r <= newProtect;
        optionNvWr_r <= 1'b1;
      end else if ((state_r == ST_UNPROT) && flashDone) begin
        // Protection drops only once the array is blank
        protect_r <= 1'b0; // RQ11
        optionNvData_r <= 1'b0;
        optionNvWr_r <= 1'b1;
      end
    end
  end

  // Sticky status flags; a new event beats a same-cycle clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      refuse_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      if (refuseNow || (ready && optWr && !privileged)) begin
        refuse_r <= 1'b1; // RQ17
      end else if (csrWr && regWrData[CSR_REFUSE_BIT]) begin
        refuse_r <= 1'b0;
      end
      if ((state_r != ST_IDLE) && flashDone) begin
        done_r <= 1'b1;
      end else if (csrWr && regWrData[CSR_DONE_BIT]) begin
        done_r <= 1'b0;
      end
    end
  end

  // Side controls that follow protection and tool presence
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      extReadGrant_r <= 1'b0;
      lsdEn_r <= 1'b0;
      pinsToTool_r <= 1'b0;
    end else begin
      extReadGrant_r <= extReadReq && loaded_r && !protect_r; // RQ9
      lsdEn_r <= loaded_r && !protect_r; // RQ12
      pinsToTool_r <= toolAttached; // RQ15
    end
  end

  // Read port: data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regRdData_r <= SFAG_CSR_RESET; // RQ16
    end else begin
      regRdData_r <= SFAG_ZERO_BYTE;
      if (regRdEn) begin
        unique case (regAddr)
          SFAG_CSR_ADDR: begin
            regRdData_r[CSR_BUSY_BIT] <= !ready; // RQ16
            regRdData_r[CSR_REFUSE_BIT] <= refuse_r;
            regRdData_r[CSR_DONE_BIT] <= done_r;
          end
          SFAG_ADRL_ADDR: begin
            regRdData_r <= addrLo_r;
          end
          SFAG_ADRH_ADDR: begin
            regRdData_r <= addrHi_r;
          end
          SFAG_DATA_ADDR: begin
            regRdData_r <= data_r;
          end
          SFAG_OPT_ADDR: begin
            regRdData_r[OPT_PROTECT_BIT] <= protect_r; // RQ10
          end
          default: begin
            regRdData_r <= SFAG_ZERO_BYTE;
          end
        endcase
      end
    end
  end

  assign regRdData = regRdData_r;
  assign flashCmd = flashCmd_r;
  assign flashCmdValid = flashCmdValid_r;
  assign optionNvWr = optionNvWr_r;
  assign optionNvData = optionNvData_r;
  assign extReadGrant = extReadGrant_r;
  assign lowSupplyDetectorEn = lsdEn_r;
  assign iccPinsToTool = pinsToTool_r;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence unprotEnter;
    (state_r == ST_IDLE) ##1 (state_r == ST_UNPROT);
  endsequence

  sequence eraseFinish;
    (state_r == ST_UNPROT) && flashDone;
  endsequence

  chk_refuse_no_cmd: assert property ( // RQ17
    refuseNow |=> !flashCmdValid_r && (state_r == ST_IDLE) && refuse_r)
    else $error("refused request reached the array");

  chk_iap_sector0: assert property ( // RQ7
    acceptOp && !privileged |-> (reqOp != OP_MERASE)
      && (targetSector != SFAG_SEC0))
    else $error("sector 0 touched outside privileged session");

  chk_protect_blocks: assert property ( // RQ9
    flashCmdValid_r && (state_r == ST_WAIT) |-> !$past(protect_r))
    else $error("flash write issued while protected");

  chk_unprot_erase: assert property ( // RQ11
    unprotEnter |-> flashCmdValid_r && (flashCmd_r.op == OP_MERASE)
      && protect_r)
    else $error("unprotect did not start with mass erase");

  chk_unprot_clear: assert property ( // RQ11
    eraseFinish |=> !protect_r && optionNvWr_r && !optionNvData_r
      && (state_r == ST_IDLE))
    else $error("protection not cleared after erase");

  chk_ext_read: assert property ( // RQ9
    extReadGrant_r |-> $past(extReadReq) && !$past(protect_r))
    else $error("external read granted while protected");

  chk_lsd_off: assert property ( // RQ12
    protect_r ##1 protect_r |-> !lsdEn_r)
    else $error("low supply detector on under protection");

  chk_pins_tool: assert property ( // RQ15
    toolAttached |=> iccPinsToTool)
    else $error("serial pins not handed to tool");

  chk_csr_reset: assert property ( // RQ16
    @(posedge sys_clk) disable iff (1'b0)
    rst |=> (state_r == ST_IDLE) && !refuse_r && !done_r
      && (regRdData_r == SFAG_CSR_RESET))
    else $error("control/status not cleared by reset");

  chk_opt_readback: assert property ( // RQ10
    regRdEn && (regAddr == SFAG_OPT_ADDR) && !optWr |=>
      regRdData_r[OPT_PROTECT_BIT] == $past(protect_r))
    else $error("option readback mismatch");

  chk_sector0_map: assert property ( // RQ4
    (targetAddr >= SFAG_SEC0_BASE) |-> (targetSector == SFAG_SEC0)
      && targetInMap)
    else $error("top page not mapped to sector 0");

  chk_op_wait: assert property ( // RQ1
    acceptOp |=> (state_r == ST_WAIT) [*1] ##0 (flashCmd_r.op == $past(reqOp)))
    else $error("accepted operation not issued");

endmodule // sfag_top

// >>> tb_top.sv
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  import sfag_pkg::*;
  localparam int unsigned KB = 60;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr, regWrData, regRdData, s;
  logic regWrEn, regRdEn, toolAttached, incircuitCommMode, optionStrap;
  logic flashDone, extReadReq, flashCmdValid, optionNvWr, optionNvData;
  logic extReadGrant, lowSupplyDetectorEn, iccPinsToTool;
  sfag_flash_cmd_s flashCmd;
  int n_fail = 0;
  int tests_run = 0;
  logic [15:0] tA [7] = '{16'hF000, 16'hFFFF, 16'hEFFF, 16'hEFFF,
                          16'h0FFF, 16'h1000, 16'hE000};
  logic [7:0] tD [7] = '{8'h11, 8'h11, 8'h11, 8'h3C, 8'h22, 8'h22, 8'h00};
  logic [7:0] tC [7] = '{8'h01, 8'h02, 8'h04, 8'h01, 8'h01, 8'h01, 8'h02};
  logic tR [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  always #5 sys_clk = ~sys_clk;

  sfag_top #(.FLASH_KB(KB)) sfag_top_inst (.sys_clk(sys_clk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .toolAttached(toolAttached),
    .incircuitCommMode(incircuitCommMode), .optionStrap(optionStrap),
    .flashDone(flashDone), .flashCmd(flashCmd),
    .flashCmdValid(flashCmdValid), .optionNvWr(optionNvWr),
    .optionNvData(optionNvData), .extReadReq(extReadReq),
    .extReadGrant(extReadGrant), .lowSupplyDetectorEn(lowSupplyDetectorEn),
    .iccPinsToTool(iccPinsToTool));

  sfag_flash_model #(.FLASH_KB(KB)) sfag_flash_model_inst (.sys_clk(sys_clk),
    .rst(rst), .flashCmd(flashCmd), .flashCmdValid(flashCmdValid),
    .flashDone(flashDone));

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1;
    s = regRdData;
  endtask

  task automatic setMode(input logic t, input logic c);
    @(posedge sys_clk);
    toolAttached <= t;
    incircuitCommMode <= c;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic doReset(input logic strap);
    @(posedge sys_clk);
    rst <= 1'b1;
    optionStrap <= strap;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  task automatic op(input logic [15:0] a, input logic [7:0] d,
                    input logic [7:0] c, input logic refused);
    int n0;
    n0 = sfag_flash_model_inst.nCmd;
    wr(SFAG_ADRL_ADDR, a[7:0]);
    wr(SFAG_ADRH_ADDR, a[15:8]);
    wr(SFAG_DATA_ADDR, d);
    wr(SFAG_CSR_ADDR, c);
    for (int i = 0; i < 40; i++) begin
      rd(SFAG_CSR_ADDR);
      if (s[CSR_BUSY_BIT] === 1'b0 && (s[CSR_REFUSE_BIT] | s[CSR_DONE_BIT]))
        break;
    end
    `CHK(s[CSR_REFUSE_BIT], refused)
    `CHK(s[CSR_DONE_BIT], !refused)
    `CHK(sfag_flash_model_inst.nCmd - n0, refused ? 0 : 1)
    wr(SFAG_CSR_ADDR, 8'h30);
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Whole sequence needs a few hundred cycles
  initial begin
    #300000;
    n_fail++;
    final_report();
  end

  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    toolAttached = 1'b0;
    incircuitCommMode = 1'b0;
    optionStrap = 1'b0;
    extReadReq = 1'b1;
    doReset(1'b0);
    rd(SFAG_CSR_ADDR); `CHK(s, SFAG_CSR_RESET)
    rd(8'h30); `CHK(s, SFAG_ZERO_BYTE)
    `CHK(extReadGrant, 1'b1)
    `CHK(lowSupplyDetectorEn, 1'b1)
    @(posedge sys_clk);
    extReadReq <= 1'b0;
    setMode(1'b1, 1'b1);
    `CHK(extReadGrant, 1'b0)
    `CHK(iccPinsToTool, 1'b1)
    @(posedge sys_clk);
    extReadReq <= 1'b1;
    $display("Test reset and side signals ended");
    op(16'h1000, 8'h77, 8'h01, 1'b0);
    `CHK(sfag_flash_model_inst.mem[16'h1000], 8'h77)
    op(16'hF000, 8'h00, 8'h04, 1'b0);
    `CHK(sfag_flash_model_inst.mem[16'h1000], 8'hFF)
    op(16'hF000, 8'hA5, 8'h01, 1'b0);
    `CHK(sfag_flash_model_inst.mem[16'hF000], 8'hA5)
    setMode(1'b0, 1'b0);
    `CHK(iccPinsToTool, 1'b0)
    $display("Test privileged access ended");
    for (int i = 0; i < 7; i++) op(tA[i], tD[i], tC[i], tR[i]);
    `CHK(sfag_flash_model_inst.mem[16'hF000], 8'hA5)
    `CHK(sfag_flash_model_inst.mem[16'hEFFF], 8'hFF)
    `CHK(sfag_flash_model_inst.mem[16'h1000], 8'h22)
    op(16'hDFFF, 8'h5A, 8'h01, 1'b0);
    rd(SFAG_ADRH_ADDR); `CHK(s, 8'hDF)
    rd(SFAG_ADRL_ADDR); `CHK(s, 8'hFF)
    rd(SFAG_DATA_ADDR); `CHK(s, 8'h5A)
    $display("Test in-application access ended");
    doReset(1'b1);
    `CHK(extReadGrant, 1'b0)
    `CHK(lowSupplyDetectorEn, 1'b0)
    rd(SFAG_OPT_ADDR); `CHK(s[OPT_PROTECT_BIT], 1'b1)
    setMode(1'b1, 1'b1);
    op(16'hDFFF, 8'h00, 8'h02, 1'b1);
    `CHK(sfag_flash_model_inst.mem[16'hDFFF], 8'h5A)
    setMode(1'b0, 1'b0);
    wr(SFAG_OPT_ADDR, 8'h00);
    rd(SFAG_CSR_ADDR); `CHK(s[CSR_REFUSE_BIT], 1'b1)
    wr(SFAG_CSR_ADDR, 8'h30);
    rd(SFAG_OPT_ADDR); `CHK(s[OPT_PROTECT_BIT], 1'b1)
    setMode(1'b1, 1'b1);
    wr(SFAG_OPT_ADDR, 8'h00);
    for (int i = 0; i < 40; i++) begin
      @(negedge sys_clk);
      if (optionNvWr === 1'b1) break;
    end
    `CHK(optionNvWr, 1'b1)
    `CHK(optionNvData, 1'b0)
    `CHK(sfag_flash_model_inst.mem[16'hDFFF], 8'hFF)
    `CHK(sfag_flash_model_inst.mem[16'hF000], 8'hFF)
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK(lowSupplyDetectorEn, 1'b1)
    `CHK(extReadGrant, 1'b1)
    wr(SFAG_OPT_ADDR, 8'h01);
    rd(SFAG_OPT_ADDR); `CHK(s[OPT_PROTECT_BIT], 1'b1)
    `CHK(optionNvData, 1'b1)
    `CHK(lowSupplyDetectorEn, 1'b0)
    $display("Test read-out protection ended");
    final_report();
  end
endmodule // tb_top
